// file: inc/sds_pkg.sv
// shared constants and carrier types of the synchronous serial dma block
package sds_pkg;
  // ==========================================================
  // timing
  localparam int CLK_HZ     = 50_000_000;
  localparam int BIT_BPS    = 250_000;
  localparam int HALF_CYC   = CLK_HZ / (2 * BIT_BPS);
  localparam int FRAME_BITS = 8;
  localparam logic [7:0] DIV_RST = 8'(HALF_CYC - 1);
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFF_RXH  = 8'h00;
  localparam logic [7:0] OFF_TXH  = 8'h04;
  localparam logic [7:0] OFF_FMT  = 8'h08;
  localparam logic [7:0] OFF_CTL  = 8'h0c;
  localparam logic [7:0] OFF_STAT = 8'h10;
  localparam logic [7:0] OFF_CARD = 8'h14;
  localparam logic [7:0] OFF_DIV  = 8'h18;
  localparam logic [7:0] OFF_CH0  = 8'h20;
  localparam logic [7:0] OFF_CH1  = 8'h40;
  // channel-relative offsets
  localparam logic [4:0] CH_SRC  = 5'h00;
  localparam logic [4:0] CH_DST  = 5'h04;
  localparam logic [4:0] CH_CNT  = 5'h08;
  localparam logic [4:0] CH_MODE = 5'h0c;
  localparam logic [4:0] CH_AM   = 5'h10;
  localparam logic [4:0] CH_RSEL = 5'h14;
  // ==========================================================
  // field positions
  localparam int CTL_TE     = 0;
  localparam int CTL_RE     = 1;
  localparam int CTL_MASTER = 2;
  localparam int CTL_READY  = 3;
  localparam int ST_TEMPTY  = 7;
  localparam int ST_RFULL   = 6;
  localparam int ST_OVR     = 5;
  localparam int ST_PER     = 4;
  localparam int ST_FER     = 3;
  localparam int ST_TEND    = 2;
  localparam int FMT_SYNC   = 7;
  localparam int CARD_SMART = 0;
  localparam int MODE_EN    = 0;
  localparam int MODE_END   = 1;
  localparam int AM_SRC_INC = 0;
  localparam int AM_DST_INC = 1;
  localparam logic [1:0] RSEL_TX = 2'h1;
  localparam logic [1:0] RSEL_RX = 2'h2;
  // ==========================================================
  // reset values and bus response codes
  localparam logic [7:0] FMT_RST = 8'h80;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } sds_axi_req_t;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } sds_axi_rsp_t;
  typedef struct packed {
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [7:0]  wdata;
  } sds_mem_req_t;
  typedef enum logic [0:0] {DMA_IDLE, DMA_XFER} sds_dma_st_t;
endpackage

// file: core/sds_core.sv
// clock-synchronous serial unit with two byte-wise dma channels
module sds_core #(
  parameter int         FRAME_BITS = sds_pkg::FRAME_BITS,
  parameter logic [7:0] DIV_INIT   = sds_pkg::DIV_RST
) (
  // clock, reset, enable
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 ce,
  // register bus
  input  wire sds_pkg::sds_axi_req_t axi_req,
  output sds_pkg::sds_axi_rsp_t      axi_rsp,
  // byte memory port of the dma engine
  output sds_pkg::sds_mem_req_t      mem_req,
  input  wire logic                 mem_ack,
  input  wire logic [31:0]          mem_rdata,
  // serial link
  output logic                      serial_out_pin,
  input  wire logic                 serial_in_pin,
  input  wire logic                 sclk_in,
  output logic                      sclk_out,
  output logic                      sclk_oe,
  input  wire logic                 slave_ready_in,
  output logic                      slave_ready_out,
  // requests and channel end
  output logic                      tx_empty_request,
  output logic                      rx_full_request,
  output logic [1:0]                xfer_end
);
  if (FRAME_BITS != 8) begin : g_chk
    $error("sds_core: only 8-bit frames are supported");
  end

  typedef struct packed {
    logic                   awf;
    logic                   wf;
    logic [7:0]             awa;
    logic [31:0]            wd;
    logic [3:0]             ws;
    logic                   bv;
    logic [1:0]             br;
    logic                   rv;
    logic [31:0]            rd;
    logic [1:0]             rr;
    logic [7:0]             tx_holding_reg;
    logic [7:0]             tx_shift_reg;
    logic [7:0]             rx_holding_reg;
    logic [7:0]             rx_shift_reg;
    logic [7:0]             fmt;
    logic [7:0]             ctl;
    logic [7:0]             card;
    logic [7:0]             div;
    logic                   temp;
    logic                   rful;
    logic                   ovr;
    logic                   parity_error_flag;
    logic                   framing_error_flag;
    logic                   txb;
    logic                   act;
    logic [2:0]             bitn;
    logic [7:0]             hcnt;
    logic                   sclk;
    logic                   sprev;
    logic                   sout;
    logic [1:0][31:0]       src;
    logic [1:0][31:0]       dst;
    logic [1:0][31:0]       cnt;
    logic [1:0][7:0]        mode;
    logic [1:0][7:0]        am;
    logic [1:0][1:0]        rsel;
    sds_pkg::sds_dma_st_t   dst_st;
    logic                   ch;
    sds_pkg::sds_mem_req_t  mem;
  } sds_state_t;

  sds_state_t s_r;
  sds_state_t s_nxt;

  // ==========================================================
  // helpers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (st[i])
        r[8*i +: 8] = d[8*i +: 8];
    end
    return r;
  endfunction

  function automatic logic [31:0] step(input logic [31:0] p, input logic inc);
    return inc ? p + 32'h1 : p;
  endfunction

  // ==========================================================
  // next state
  logic       fall;
  logic       rise;
  logic       fend;
  logic       norm;
  logic       te;
  logic       re;
  logic       mst;
  logic       start;
  logic [1:0] chreq;
  logic       c;
  logic [4:0] coff;
  logic       chsel;

  always_comb
  begin
    s_nxt = s_r;
    fall  = 1'b0;
    rise  = 1'b0;
    fend  = 1'b0;
    c     = 1'b0;
    coff  = 5'h00;
    chsel = 1'b0;
    chreq = 2'b00;
    // smart-card setting halts the normal serial engine
    norm  = !s_r.card[sds_pkg::CARD_SMART] && s_r.fmt[sds_pkg::FMT_SYNC];
    te    = s_r.ctl[sds_pkg::CTL_TE];
    re    = s_r.ctl[sds_pkg::CTL_RE];
    mst   = s_r.ctl[sds_pkg::CTL_MASTER];
    start = 1'b0;

    // ---- bus channels, each captured independently
    if (axi_req.awvalid && !s_r.awf)
    begin
      s_nxt.awf = 1'b1;
      s_nxt.awa = axi_req.awaddr;
    end
    if (axi_req.wvalid && !s_r.wf)
    begin
      s_nxt.wf = 1'b1;
      s_nxt.wd = axi_req.wdata;
      s_nxt.ws = axi_req.wstrb;
    end
    if (s_r.bv && axi_req.bready)
      s_nxt.bv = 1'b0;
    if (s_r.rv && axi_req.rready)
      s_nxt.rv = 1'b0;

    // ---- register write, once address and data are both held
    if (s_r.awf && s_r.wf && !s_r.bv)
    begin
      s_nxt.awf = 1'b0;
      s_nxt.wf  = 1'b0;
      s_nxt.bv  = 1'b1;
      s_nxt.br  = sds_pkg::RESP_OK;
      chsel = s_r.awa >= sds_pkg::OFF_CH1;
      coff  = 5'(s_r.awa - (chsel ? sds_pkg::OFF_CH1 : sds_pkg::OFF_CH0));
      case (s_r.awa)
        // rx holding ignores writes, answers okay
        sds_pkg::OFF_RXH: ;
        sds_pkg::OFF_TXH:
          if (s_r.ws[0]) s_nxt.tx_holding_reg = s_r.wd[7:0];
        sds_pkg::OFF_FMT:
          if (s_r.ws[0]) s_nxt.fmt = s_r.wd[7:0];
        sds_pkg::OFF_CTL:
          if (s_r.ws[0]) s_nxt.ctl = s_r.wd[7:0];
        sds_pkg::OFF_CARD:
          if (s_r.ws[0]) s_nxt.card = s_r.wd[7:0];
        sds_pkg::OFF_DIV:
          if (s_r.ws[0]) s_nxt.div = s_r.wd[7:0];
        sds_pkg::OFF_STAT:
          if (s_r.ws[0])
          begin
            // writing zero clears, writing one does nothing
            s_nxt.temp = s_r.temp & s_r.wd[sds_pkg::ST_TEMPTY];
            s_nxt.rful = s_r.rful & s_r.wd[sds_pkg::ST_RFULL];
            s_nxt.ovr  = s_r.ovr & s_r.wd[sds_pkg::ST_OVR];
            s_nxt.parity_error_flag  = s_r.parity_error_flag & s_r.wd[sds_pkg::ST_PER];
            s_nxt.framing_error_flag  = s_r.framing_error_flag & s_r.wd[sds_pkg::ST_FER];
          end
        default:
          if ((s_r.awa >= sds_pkg::OFF_CH0) && (s_r.awa < sds_pkg::OFF_CH1 + 8'h18))
          begin
            case (coff)
              sds_pkg::CH_SRC:  s_nxt.src[chsel] = merge(s_r.src[chsel], s_r.wd, s_r.ws);
              sds_pkg::CH_DST:  s_nxt.dst[chsel] = merge(s_r.dst[chsel], s_r.wd, s_r.ws);
              sds_pkg::CH_CNT:  s_nxt.cnt[chsel] = merge(s_r.cnt[chsel], s_r.wd, s_r.ws);
              sds_pkg::CH_MODE: if (s_r.ws[0]) s_nxt.mode[chsel] = s_r.wd[7:0];
              sds_pkg::CH_AM:   if (s_r.ws[0]) s_nxt.am[chsel] = s_r.wd[7:0];
              sds_pkg::CH_RSEL: if (s_r.ws[0]) s_nxt.rsel[chsel] = s_r.wd[1:0];
              default:          s_nxt.br = sds_pkg::RESP_ERR;
            endcase
          end
          else
            s_nxt.br = sds_pkg::RESP_ERR;
      endcase
    end

    // ---- register read
    if (axi_req.arvalid && !s_r.rv)
    begin
      s_nxt.rv = 1'b1;
      s_nxt.rr = sds_pkg::RESP_OK;
      s_nxt.rd = 32'h0;
      chsel = axi_req.araddr >= sds_pkg::OFF_CH1;
      coff  = 5'(axi_req.araddr - (chsel ? sds_pkg::OFF_CH1 : sds_pkg::OFF_CH0));
      case (axi_req.araddr)
        sds_pkg::OFF_RXH:  s_nxt.rd[7:0] = s_r.rx_holding_reg;
        sds_pkg::OFF_TXH:  s_nxt.rd[7:0] = s_r.tx_holding_reg;
        sds_pkg::OFF_FMT:  s_nxt.rd[7:0] = s_r.fmt;
        sds_pkg::OFF_CTL:  s_nxt.rd[7:0] = s_r.ctl;
        sds_pkg::OFF_CARD: s_nxt.rd[7:0] = s_r.card;
        sds_pkg::OFF_DIV:  s_nxt.rd[7:0] = s_r.div;
        sds_pkg::OFF_STAT:
        begin
          s_nxt.rd[sds_pkg::ST_TEMPTY] = s_r.temp;
          s_nxt.rd[sds_pkg::ST_RFULL]  = s_r.rful;
          s_nxt.rd[sds_pkg::ST_OVR]    = s_r.ovr;
          s_nxt.rd[sds_pkg::ST_PER]    = s_r.parity_error_flag;
          s_nxt.rd[sds_pkg::ST_FER]    = s_r.framing_error_flag;
          s_nxt.rd[sds_pkg::ST_TEND]   = s_r.temp && !s_r.txb;
        end
        default:
          if ((axi_req.araddr >= sds_pkg::OFF_CH0) &&
              (axi_req.araddr < sds_pkg::OFF_CH1 + 8'h18))
          begin
            case (coff)
              sds_pkg::CH_SRC:  s_nxt.rd = s_r.src[chsel];
              sds_pkg::CH_DST:  s_nxt.rd = s_r.dst[chsel];
              sds_pkg::CH_CNT:  s_nxt.rd = s_r.cnt[chsel];
              sds_pkg::CH_MODE: s_nxt.rd[7:0] = s_r.mode[chsel];
              sds_pkg::CH_AM:   s_nxt.rd[7:0] = s_r.am[chsel];
              sds_pkg::CH_RSEL: s_nxt.rd[1:0] = s_r.rsel[chsel];
              default:          s_nxt.rr = sds_pkg::RESP_ERR;
            endcase
          end
          else
            s_nxt.rr = sds_pkg::RESP_ERR;
      endcase
    end

    // ---- dma engine, channel 0 has priority
    for (int i = 0; i < 2; i++)
    begin
      // request select picks the trigger, mode enables
      chreq[i] = s_r.mode[i][sds_pkg::MODE_EN] && (s_r.cnt[i] != 32'h0) &&
                 (((s_r.rsel[i] == sds_pkg::RSEL_TX) && s_r.temp && te) ||
                  ((s_r.rsel[i] == sds_pkg::RSEL_RX) && s_r.rful));
    end
    case (s_r.dst_st)
      sds_pkg::DMA_IDLE:
        if (chreq != 2'b00)
        begin
          c = !chreq[0];
          s_nxt.ch     = c;
          s_nxt.dst_st = sds_pkg::DMA_XFER;
          s_nxt.mem.req = 1'b1;
          // tx trigger fetches a byte from the source area
          if (s_r.rsel[c] == sds_pkg::RSEL_TX)
          begin
            s_nxt.mem.we   = 1'b0;
            s_nxt.mem.addr = s_r.src[c];
          end
          // rx trigger stores the holding byte to memory
          else
          begin
            s_nxt.mem.we    = 1'b1;
            s_nxt.mem.addr  = s_r.dst[c];
            s_nxt.mem.wdata = s_r.rx_holding_reg;
          end
        end
      sds_pkg::DMA_XFER:
        if (mem_ack)
        begin
          c = s_r.ch;
          s_nxt.mem.req = 1'b0;
          s_nxt.dst_st  = sds_pkg::DMA_IDLE;
          if (!s_r.mem.we)
          begin
            s_nxt.tx_holding_reg = mem_rdata[7:0];
            s_nxt.temp = 1'b0;
          end
          else
            s_nxt.rful = 1'b0;
          // source and destination pointers step per address method
          s_nxt.src[c] = step(s_r.src[c], s_r.am[c][sds_pkg::AM_SRC_INC]);
          s_nxt.dst[c] = step(s_r.dst[c], s_r.am[c][sds_pkg::AM_DST_INC]);
          // one byte moved, one less remaining
          s_nxt.cnt[c] = s_r.cnt[c] - 32'h1;
          // last byte disables channel and flags end
          if (s_r.cnt[c] == 32'h1)
          begin
            s_nxt.mode[c][sds_pkg::MODE_EN]  = 1'b0;
            s_nxt.mode[c][sds_pkg::MODE_END] = 1'b1;
          end
        end
      default: s_nxt.dst_st = sds_pkg::DMA_IDLE;
    endcase

    // ---- serial clock edges
    s_nxt.sprev = sclk_in;
    if (norm && (te || re))
    begin
      if (mst)
      begin
        // master times edges from its divisor
        if (s_r.act)
        begin
          if (s_r.hcnt == 8'h0)
          begin
            s_nxt.hcnt = s_r.div;
            s_nxt.sclk = !s_r.sclk;
            fall = s_r.sclk;
            rise = !s_r.sclk;
          end
          else
            s_nxt.hcnt = s_r.hcnt - 8'h1;
        end
        else
        begin
          // no clocking until the slave reports ready
          start = slave_ready_in &&
                  ((te && s_r.txb) || (!te && re && !s_r.rful && !s_r.ovr));
          if (start)
          begin
            s_nxt.act  = 1'b1;
            s_nxt.hcnt = s_r.div;
          end
        end
      end
      else
      begin
        // slave follows edges of the incoming clock
        fall = s_r.sprev && !sclk_in;
        rise = !s_r.sprev && sclk_in;
      end
    end

    // ---- shifting: drive on falling, sample on rising
    if (fall)
      s_nxt.sout = s_r.txb ? s_r.tx_shift_reg[s_r.bitn] : 1'b1;
    if (rise)
    begin
      s_nxt.rx_shift_reg = {serial_in_pin, s_r.rx_shift_reg[7:1]};
      s_nxt.bitn = s_r.bitn + 3'h1;
      if (s_r.bitn == 3'(FRAME_BITS - 1))
      begin
        fend = 1'b1;
        s_nxt.bitn = 3'h0;
        s_nxt.act  = 1'b0;
      end
    end
    if (fend)
    begin
      s_nxt.txb = 1'b0;
      if (re)
      begin
        // unread byte is kept, the new one is lost
        if (s_nxt.rful)
          s_nxt.ovr = 1'b1;
        else
        begin
          // whole frame moves to rx holding
          s_nxt.rx_holding_reg = {serial_in_pin, s_r.rx_shift_reg[7:1]};
          s_nxt.rful = 1'b1;
        end
      end
    end

    // idle shifter takes the waiting byte
    // checked after frame end, so no gap
    // registered flag: a dma fill while the shifter is idle shows tx-empty low for a cycle
    if (norm && te && !s_nxt.txb && !s_r.temp)
    begin
      s_nxt.tx_shift_reg = s_nxt.tx_holding_reg;
      s_nxt.txb = 1'b1;
      s_nxt.temp = 1'b1;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_r       <= '0;
      s_r.fmt   <= sds_pkg::FMT_RST;
      s_r.div   <= DIV_INIT;
      s_r.temp  <= 1'b1;
      s_r.sclk  <= 1'b1;
      s_r.sprev <= 1'b1;
      s_r.sout  <= 1'b1;
    end
    else if (ce)
      s_r <= s_nxt;
  end

  // ==========================================================
  // outputs
  always_comb
  begin
    axi_rsp.awready  = !s_r.awf;
    axi_rsp.wready   = !s_r.wf;
    axi_rsp.bvalid   = s_r.bv;
    axi_rsp.bresp    = s_r.br;
    axi_rsp.arready  = !s_r.rv;
    axi_rsp.rvalid   = s_r.rv;
    axi_rsp.rdata    = s_r.rd;
    axi_rsp.rresp    = s_r.rr;
    mem_req          = s_r.mem;
    serial_out_pin   = s_r.sout;
    sclk_out         = s_r.sclk;
    sclk_oe          = s_r.ctl[sds_pkg::CTL_MASTER];
    slave_ready_out  = s_r.ctl[sds_pkg::CTL_READY];
    tx_empty_request = s_r.temp && s_r.ctl[sds_pkg::CTL_TE];
    rx_full_request  = s_r.rful;
    xfer_end[0]      = s_r.mode[0][sds_pkg::MODE_END];
    xfer_end[1]      = s_r.mode[1][sds_pkg::MODE_END];
  end
endmodule

// file: tb/sds_core_asserts.sv
// port-level checks of the serial dma core
module sds_chk (
  // clock and reset
  input wire logic                  aclk,
  input wire logic                  aresetn,
  // register bus
  input wire sds_pkg::sds_axi_req_t axi_req,
  input wire sds_pkg::sds_axi_rsp_t axi_rsp,
  // memory port
  input wire sds_pkg::sds_mem_req_t mem_req,
  input wire logic                  mem_ack,
  // serial link
  input wire logic                  serial_out_pin,
  input wire logic                  sclk_out,
  input wire logic                  sclk_oe,
  input wire logic                  slave_ready_in,
  // requests and channel end
  input wire logic                  tx_empty_request,
  input wire logic                  rx_full_request,
  input wire logic [1:0]            xfer_end
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ==========
  // dma side
  AST_MEM_HOLD: assert property (mem_req.req && !mem_ack |=>
    mem_req.req && $stable(mem_req)) else $error("memory request moved before ack");
  AST_TXE_CLR: assert property (mem_req.req && !mem_req.we && mem_ack |=>
    !tx_empty_request) else $error("tx empty kept after channel 0 transfer");
  AST_RXF_CLR: assert property (mem_req.req && mem_req.we && mem_ack |=>
    !rx_full_request) else $error("rx full kept after channel 1 transfer");
  AST_END_CAUSE: assert property ($rose(xfer_end[0]) |->
    $past(mem_req.req && mem_ack && !mem_req.we)) else $error("end without transfer");
  AST_END_HALT: assert property (xfer_end == 2'b11 |-> !mem_req.req)
    else $error("memory access after both channels ended");
  // ==========
  // register bus
  AST_B_AFTER: assert property ($rose(axi_rsp.bvalid) |->
    $past(!axi_rsp.awready && !axi_rsp.wready)) else $error("write answer without request");
  AST_AR_ANSWER: assert property (axi_req.arvalid && axi_rsp.arready |=>
    axi_rsp.rvalid) else $error("read answer late");
  // ==========
  // serial link
  AST_DATA_STEADY: assert property (sclk_oe && $rose(sclk_out) |->
    $stable(serial_out_pin) ##1 $stable(serial_out_pin)) else $error("data moved at sample");
  AST_CLK_READY: assert property (sclk_oe && $fell(sclk_out) |-> slave_ready_in)
    else $error("clock ran while peer not ready");
  AST_RXF_END: assert property (sclk_oe && $rose(rx_full_request) |-> sclk_out)
    else $error("rx full mid bit");
endmodule

bind sds_core sds_chk u_chk (.aclk, .aresetn, .axi_req, .axi_rsp, .mem_req, .mem_ack,
  .serial_out_pin, .sclk_out, .sclk_oe, .slave_ready_in, .tx_empty_request,
  .rx_full_request, .xfer_end);

// file: tb/sds_peer.sv
// slave peer serial unit clocked by the core
module sds_peer #(
  parameter int N_MAX     = 16,
  parameter int READY_DLY = 300
) (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // serial link
  input  wire logic       sclk,
  input  wire logic       sdi,
  output logic            sdo,
  output logic            ready,
  // bytes sent and received
  input  wire logic [7:0] tx_bytes [N_MAX],
  output logic [7:0]      rx_log [N_MAX],
  output int              n_rx
);
  timeunit 1ns;
  timeprecision 1ns;
  int         wait_cyc;
  int         n_bit = 0;
  logic [7:0] sh;
  initial
  begin
    sdo  = 1'b1;
    n_rx = 0;
  end
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wait_cyc <= 0;
      ready    <= 1'b0;
    end
    else if (wait_cyc < READY_DLY)
      wait_cyc <= wait_cyc + 1;
    else
      ready <= 1'b1;
  end
  always @(negedge sclk)
    if (n_rx < N_MAX)
      sdo <= tx_bytes[n_rx][n_bit];
  always @(posedge sclk)
  begin
    // clock leaving unknown in reset is no data edge
    if (!aresetn)
      n_bit = 0;
    else
    begin
      sh = {sdi, sh[7:1]};
      n_bit = n_bit + 1;
      if (n_bit == 8)
      begin
        rx_log[n_rx] <= sh;
        n_rx <= n_rx + 1;
        n_bit = 0;
        // hold time over: line no longer shows the bit
        #30 sdo <= ~sdo;
      end
    end
  end
endmodule

// file: tb/sds_core_test.sv
// self-checking bench of the serial dma core against a slave peer
module sds_core_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] DIV   = 8'h02;
  localparam int         LIMIT = 5000;
  logic                  aclk      = 1'b0;
  logic                  aresetn   = 1'b0;
  sds_pkg::sds_axi_req_t axi_req   = '0;
  sds_pkg::sds_axi_rsp_t axi_rsp;
  sds_pkg::sds_mem_req_t mem_req;
  sds_pkg::sds_mem_req_t m;
  logic                  mem_ack   = 1'b0;
  logic [31:0]           mem_rdata = '0;
  logic                  sdo, sdi, sclk, sclk_oe, rdy, rdy_out, txr, rxr;
  logic [1:0]            xend;
  logic [7:0]            sent [16];
  logic [7:0]            got [16];
  logic [31:0]           src0, dst1, rd;
  logic [1:0]            resp;
  int                    seed = 75, n_errors = 0, comparisons = 0, cyc = 0;
  int                    n, n_rx, n_rd = 0, n_wr = 0, n_early = 0;
  time                   last_fall = 0, gap = 0;

  sds_core #(.DIV_INIT(DIV)) u_sds_core (.aclk, .aresetn, .ce(1'b1), .axi_req, .axi_rsp,
    .mem_req, .mem_ack, .mem_rdata, .serial_out_pin(sdo), .serial_in_pin(sdi),
    .sclk_in(1'b1), .sclk_out(sclk), .sclk_oe, .slave_ready_in(rdy),
    .slave_ready_out(rdy_out), .tx_empty_request(txr), .rx_full_request(rxr),
    .xfer_end(xend));
  sds_peer u_sds_peer (.aclk, .aresetn, .sclk, .sdi(sdo), .sdo(sdi), .ready(rdy),
    .tx_bytes(sent), .rx_log(got), .n_rx);

  always #10 aclk = ~aclk;

  task automatic stop_test();
  begin
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask

  task automatic chk(input logic ok, input string msg);
  begin
    comparisons++;
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  end
  endtask

  function automatic logic [7:0] rb(input logic [31:0] a);
    return a[7:0] ^ 8'h3c;
  endfunction

  // ==========
  // register bus master
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
  begin
    @(posedge aclk);
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr  <= a;
    axi_req.wvalid  <= 1'b1;
    axi_req.wdata   <= d;
    axi_req.wstrb   <= 4'hf;
    axi_req.bready  <= 1'b1;
    b = 1'b0;
    while (!b)
    begin
      @(negedge aclk);
      aw   = axi_req.awvalid && axi_rsp.awready;
      w    = axi_req.wvalid && axi_rsp.wready;
      b    = axi_rsp.bvalid;
      resp = axi_rsp.bresp;
      @(posedge aclk);
      if (aw) axi_req.awvalid <= 1'b0;
      if (w) axi_req.wvalid <= 1'b0;
      if (b) axi_req.bready <= 1'b0;
    end
  end
  endtask

  task automatic rd_reg(input logic [7:0] a);
    logic ar, r;
  begin
    @(posedge aclk);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr  <= a;
    axi_req.rready  <= 1'b1;
    r = 1'b0;
    while (!r)
    begin
      @(negedge aclk);
      ar   = axi_req.arvalid && axi_rsp.arready;
      r    = axi_rsp.rvalid;
      rd   = axi_rsp.rdata;
      resp = axi_rsp.rresp;
      @(posedge aclk);
      if (ar) axi_req.arvalid <= 1'b0;
      if (r) axi_req.rready <= 1'b0;
    end
  end
  endtask

  task automatic exp_rd(input logic [7:0] a, input logic [31:0] mk, input logic [31:0] e);
  begin
    rd_reg(a);
    chk((rd & mk) === e && resp === sds_pkg::RESP_OK, $sformatf("read %h", a));
  end
  endtask

  task automatic cfg(input logic [7:0] b, input logic [31:0] s, input logic [31:0] d,
                     input logic [31:0] am, input logic [31:0] sel);
  begin
    wr(b + sds_pkg::CH_SRC, s);
    wr(b + sds_pkg::CH_DST, d);
    wr(b + sds_pkg::CH_CNT, n);
    wr(b + sds_pkg::CH_AM, am);
    wr(b + sds_pkg::CH_RSEL, sel);
    wr(b + sds_pkg::CH_MODE, 32'h1);
  end
  endtask

  // ==========
  // byte memory with random latency
  always @(negedge aclk) m = mem_req;
  always @(posedge aclk)
  begin
    if (m.req && !mem_ack && ($random(seed) & 1))
    begin
      mem_ack <= 1'b1;
      if (m.we)
      begin
        chk(m.addr === dst1 + n_wr, "write address");
        chk(m.wdata === sent[n_wr], "write data");
        n_wr++;
      end
      else
      begin
        chk(m.addr === src0 + n_rd, "read address");
        mem_rdata <= {24'h0, rb(m.addr)};
        n_rd++;
      end
    end
    else
    begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end
  end

  // ==========
  // watchdog and serial clock monitor
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      n_errors++;
      stop_test();
    end
  end
  always @(negedge sclk)
  begin
    if (!rdy) n_early++;
    if (last_fall != 0 && $time - last_fall > gap) gap = $time - last_fall;
    last_fall = $time;
  end

  // ==========
  // main sequence
  initial
  begin
    n    = 4 + ($random(seed) & 3);
    src0 = $random(seed);
    dst1 = 32'hffff_fffe;
    for (int k = 0; k < 16; k++)
      sent[k] = 8'($random(seed));
    sent[0] = 8'h01;
    sent[1] = 8'h80;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    exp_rd(sds_pkg::OFF_FMT, 32'hff, {24'h0, sds_pkg::FMT_RST});
    exp_rd(sds_pkg::OFF_DIV, 32'hff, {24'h0, DIV});
    exp_rd(sds_pkg::OFF_STAT, 32'hf8, 32'h80);
    rd_reg(8'h1c);
    chk(resp === sds_pkg::RESP_ERR, "unmapped read");
    wr(8'h1c, 32'hffff_ffff);
    chk(resp === sds_pkg::RESP_ERR, "unmapped write");
    cfg(sds_pkg::OFF_CH0, src0, {24'h0, sds_pkg::OFF_TXH}, 32'h1, 32'h1);
    cfg(sds_pkg::OFF_CH1, {24'h0, sds_pkg::OFF_RXH}, dst1, 32'h2, 32'h2);
    wr(sds_pkg::OFF_CTL, 32'hf);
    chk(rdy_out === 1'b1, "ready out");
    while (!(xend === 2'b11 && n_rx == n))
      @(posedge aclk);
    chk(n_early == 0, "clock before ready");
    chk(gap <= 2 * (DIV + 1) * 20 + 60, "gap between frames");
    for (int k = 0; k < n; k++)
      chk(got[k] === rb(src0 + k), "byte at peer");
    chk(n_rd == n && n_wr == n, "transfer count");
    exp_rd(sds_pkg::OFF_CH0 + sds_pkg::CH_CNT, 32'hffff_ffff, 32'h0);
    exp_rd(sds_pkg::OFF_CH1 + sds_pkg::CH_CNT, 32'hffff_ffff, 32'h0);
    exp_rd(sds_pkg::OFF_CH0 + sds_pkg::CH_SRC, 32'hffff_ffff, src0 + n);
    exp_rd(sds_pkg::OFF_CH1 + sds_pkg::CH_DST, 32'hffff_ffff, dst1 + n);
    exp_rd(sds_pkg::OFF_CH0 + sds_pkg::CH_DST, 32'hff, {24'h0, sds_pkg::OFF_TXH});
    exp_rd(sds_pkg::OFF_CH0 + sds_pkg::CH_MODE, 32'h3, 32'h2);
    exp_rd(sds_pkg::OFF_RXH, 32'hffff_ffff, {24'h0, sent[n-1]});
    wr(sds_pkg::OFF_RXH, {24'h0, ~sent[n-1]});
    exp_rd(sds_pkg::OFF_RXH, 32'hffff_ffff, {24'h0, sent[n-1]});
    wr(sds_pkg::OFF_CARD, 32'h1);
    wr(sds_pkg::OFF_STAT, 32'h0);
    exp_rd(sds_pkg::OFF_STAT, 32'hf8, 32'h0);
    wr(sds_pkg::OFF_STAT, 32'hff);
    exp_rd(sds_pkg::OFF_STAT, 32'hf8, 32'h0);
    stop_test();
  end
endmodule
